//--- logic/hco_overlay.sv
/*
  Hardware cursor overlay: indexed control registers, per-line mask prefetch and pixel mix.
  Assumes the refresh pipeline gives frame_start and line_start pulses and one pixel per
  pix_valid, and that the memory port returns a word some cycles after mem_req, on mem_ack.
*/
// Behaviour
// - Bit 4 picks windowing or X11 table
// - 64x64 cursor from AND, XOR masks
// - Windowing table: bg, fg, screen, inverted
// - X11: screen when AND 0, else bg/fg
// - Two three-byte color stacks, one index each
// - Mode register read zeroes both stack pointers
// - Writes load low, second, third byte
// - Cursor off unless enhanced mode set
// - Mode bit 0 enables the cursor
// - Control writes other than lock accepted only when A0 unlocked
// - X and Y are 11-bit, 0 to 2047
// - Coordinates from high 3, low 8 bits
// - Clip right/bottom; hide Y past height
// - Row skip hides top rows
// - Column skip hides left columns
// - Position applied once per frame
// - Masks fetched AND/XOR word interleaved
// - Pattern base is 1 KB segment number
`timescale 1ns/100ps
module hco_overlay
  import hco_pkg::*;
#(
  parameter int MEM_AW = 20
)(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_idx,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  input  wire logic              enhanced_mode,
  input  wire logic [10:0]       active_height,
  input  wire logic              frame_start,
  input  wire logic              line_start,
  input  wire logic [10:0]       fetch_line,
  input  wire logic              pix_valid,
  input  wire logic [10:0]       hpos,
  input  wire logic [10:0]       vpos,
  input  wire logic [23:0]       screen_pixel,
  output logic      [23:0]       out_pixel,
  output logic                   out_valid,
  output logic                   mem_req,
  output logic      [MEM_AW-1:0] mem_addr,
  input  wire logic              mem_ack,
  input  wire logic [15:0]       mem_rdata,
  output logic                   cursor_on
);

  // ==========================================================
  // Control registers
  logic [7:0]  lock_q, lock_d, mode_q, mode_d, conv_q, conv_d;
  logic [7:0]  sth_q, sth_d, stl_q, stl_d;
  logic [7:0]  fg_q [3], fg_d [3], bg_q [3], bg_d [3];
  logic [1:0]  fptr_q, fptr_d, bptr_q, bptr_d;
  hco_pos_s    pos_q, pos_d;
  logic [7:0]  rdata_d;
  logic        unlocked;

  function automatic logic [1:0] ptr_next(input logic [1:0] p);
    ptr_next = (p == 2'h2) ? 2'h0 : p + 2'h1;
  endfunction

  assign unlocked = (lock_q == UNLOCK_KEY);

  always_comb
  begin
    lock_d  = lock_q;
    mode_d  = mode_q;
    conv_d  = conv_q;
    sth_d   = sth_q;
    stl_d   = stl_q;
    pos_d   = pos_q;
    fptr_d  = fptr_q;
    bptr_d  = bptr_q;
    fg_d    = fg_q;
    bg_d    = bg_q;
    rdata_d = 8'h00;
    if (reg_wr && reg_idx == IDX_LOCK)
      lock_d = reg_wdata;
    if (reg_wr && unlocked)
    begin
      case (reg_idx)
        IDX_MODE: mode_d = reg_wdata;
        IDX_CONV: conv_d = reg_wdata;
        IDX_XH:   pos_d.x[10:8] = reg_wdata[2:0];
        IDX_XL:   pos_d.x[7:0]  = reg_wdata;
        IDX_YH:   pos_d.y[10:8] = reg_wdata[2:0];
        IDX_YL:   pos_d.y[7:0]  = reg_wdata;
        IDX_COL_SKIP: pos_d.col_skip = reg_wdata[5:0];
        IDX_ROW_SKIP: pos_d.row_skip = reg_wdata[5:0];
        IDX_STH:  sth_d = {4'h0, reg_wdata[3:0]};
        IDX_STL:  stl_d = reg_wdata;
        IDX_FG:
        begin
          fg_d[fptr_q] = reg_wdata;
          fptr_d = ptr_next(fptr_q);
        end
        IDX_BG:
        begin
          bg_d[bptr_q] = reg_wdata;
          bptr_d = ptr_next(bptr_q);
        end
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_idx)
        IDX_LOCK: rdata_d = lock_q;
        IDX_MODE: rdata_d = mode_q;
        IDX_CONV: rdata_d = conv_q;
        IDX_XH:   rdata_d = {5'h00, pos_q.x[10:8]};
        IDX_XL:   rdata_d = pos_q.x[7:0];
        IDX_YH:   rdata_d = {5'h00, pos_q.y[10:8]};
        IDX_YL:   rdata_d = pos_q.y[7:0];
        IDX_COL_SKIP: rdata_d = {2'h0, pos_q.col_skip};
        IDX_ROW_SKIP: rdata_d = {2'h0, pos_q.row_skip};
        IDX_STH:  rdata_d = sth_q;
        IDX_STL:  rdata_d = stl_q;
        IDX_FG:   rdata_d = fg_q[fptr_q];
        IDX_BG:   rdata_d = bg_q[bptr_q];
        default:  rdata_d = 8'h00;
      endcase
      if (reg_idx == IDX_MODE)
      begin
        fptr_d = 2'h0;
        bptr_d = 2'h0;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      lock_q    <= RESET_BYTE;
      mode_q    <= RESET_BYTE;
      conv_q    <= RESET_BYTE;
      sth_q     <= RESET_BYTE;
      stl_q     <= RESET_BYTE;
      pos_q     <= '0;
      fptr_q    <= 2'h0;
      bptr_q    <= 2'h0;
      fg_q      <= '{default: RESET_BYTE};
      bg_q      <= '{default: RESET_BYTE};
      reg_rdata <= 8'h00;
    end
    else
    begin
      lock_q    <= lock_d;
      mode_q    <= mode_d;
      conv_q    <= conv_d;
      sth_q     <= sth_d;
      stl_q     <= stl_d;
      pos_q     <= pos_d;
      fptr_q    <= fptr_d;
      bptr_q    <= bptr_d;
      fg_q      <= fg_d;
      bg_q      <= bg_d;
      reg_rdata <= rdata_d;
    end
  end

  // ==========================================================
  // Frame and line shadows
  // Shadows keep a line on screen consistent while software edits
  hco_pos_s    fpos_q, fpos_d;
  logic        en_q, en_d, x11_q, x11_d;
  logic [23:0] fgc_q, fgc_d, bgc_q, bgc_d;

  always_comb
  begin
    fpos_d = frame_start ? pos_q : fpos_q;
    en_d   = en_q;
    x11_d  = x11_q;
    fgc_d  = fgc_q;
    bgc_d  = bgc_q;
    if (line_start)
    begin
      en_d  = mode_q[ENABLE_BIT] && enhanced_mode;
      x11_d = conv_q[CONV_BIT];
      fgc_d = {fg_q[2], fg_q[1], fg_q[0]};
      bgc_d = {bg_q[2], bg_q[1], bg_q[0]};
    end
    if (!enhanced_mode)
      en_d = 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      fpos_q <= '0;
      en_q   <= 1'b0;
      x11_q  <= 1'b0;
      fgc_q  <= 24'h000000;
      bgc_q  <= 24'h000000;
    end
    else
    begin
      fpos_q <= fpos_d;
      en_q   <= en_d;
      x11_q  <= x11_d;
      fgc_q  <= fgc_d;
      bgc_q  <= bgc_d;
    end
  end

  assign cursor_on = en_q;

  // ==========================================================
  // Mask prefetch
  // One line ahead: fetch for fetch_line while the current line shows
  hco_state_e  st_q, st_d;
  logic [2:0]  wcnt_q, wcnt_d;
  logic [5:0]  frow_q, frow_d;
  logic        fhit_q, fhit_d, shit_q, shit_d;
  logic [63:0] fand_q, fand_d, fxor_q, fxor_d, sand_q, sand_d, sxor_q, sxor_d;
  logic [11:0] fdy;
  logic        row_hit;
  logic [7:0]  word_idx;

  assign fdy      = {1'b0, fetch_line} - {1'b0, fpos_q.y} + {6'h00, fpos_q.row_skip};
  assign row_hit  = (fetch_line >= fpos_q.y) && (fdy < 12'(CUR_SIZE))
                    && (fpos_q.y < active_height);
  assign word_idx = {frow_q, wcnt_q[2:1]};
  // Segment base, then 16-bit word index with AND/XOR interleave
  assign mem_addr = (MEM_AW'({sth_q[3:0], stl_q}) << SEG_WORD_SHIFT)
                    + MEM_AW'({word_idx, wcnt_q[0]});
  assign mem_req  = (st_q == HCO_FETCH);

  always_comb
  begin
    st_d   = st_q;
    wcnt_d = wcnt_q;
    frow_d = frow_q;
    fhit_d = fhit_q;
    fand_d = fand_q;
    fxor_d = fxor_q;
    sand_d = sand_q;
    sxor_d = sxor_q;
    shit_d = shit_q;
    case (st_q)
      HCO_IDLE: ;
      HCO_FETCH:
        if (mem_ack)
        begin
          if (wcnt_q[0])
            fxor_d[16*(3-wcnt_q[2:1]) +: 16] = mem_rdata;
          else
            fand_d[16*(3-wcnt_q[2:1]) +: 16] = mem_rdata;
          wcnt_d = wcnt_q + 3'h1;
          if (wcnt_q == 3'h7)
            st_d = HCO_IDLE;
        end
      default: st_d = HCO_IDLE;
    endcase
    if (line_start)
    begin
      sand_d = fand_q;
      sxor_d = fxor_q;
      shit_d = fhit_q && (st_q == HCO_IDLE);
      fhit_d = row_hit;
      frow_d = fdy[5:0];
      wcnt_d = 3'h0;
      st_d   = row_hit ? HCO_FETCH : HCO_IDLE;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_q   <= HCO_IDLE;
      wcnt_q <= 3'h0;
      frow_q <= 6'h00;
      fhit_q <= 1'b0;
      shit_q <= 1'b0;
      fand_q <= '1;
      fxor_q <= '0;
      sand_q <= '1;
      sxor_q <= '0;
    end
    else
    begin
      st_q   <= st_d;
      wcnt_q <= wcnt_d;
      frow_q <= frow_d;
      fhit_q <= fhit_d;
      shit_q <= shit_d;
      fand_q <= fand_d;
      fxor_q <= fxor_d;
      sand_q <= sand_d;
      sxor_q <= sxor_d;
    end
  end

  // ==========================================================
  // Pixel mix
  logic [11:0] dx;
  logic        col_hit, and_b, xor_b;
  logic [23:0] pix_d;
  logic [5:0]  col;

  assign dx      = {1'b0, hpos} - {1'b0, fpos_q.x} + {6'h00, fpos_q.col_skip};
  assign col_hit = (hpos >= fpos_q.x) && (dx < 12'(CUR_SIZE));
  assign col     = dx[5:0];
  assign and_b   = sand_q[6'd63 - col];
  assign xor_b   = sxor_q[6'd63 - col];

  always_comb
  begin
    pix_d = screen_pixel;
    if (en_q && shit_q && col_hit)
    begin
      case ({x11_q, and_b, xor_b})
        3'b000:  pix_d = bgc_q;
        3'b001:  pix_d = fgc_q;
        3'b010:  pix_d = screen_pixel;
        3'b011:  pix_d = ~screen_pixel;
        3'b110:  pix_d = bgc_q;
        3'b111:  pix_d = fgc_q;
        default: pix_d = screen_pixel;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      out_pixel <= 24'h000000;
      out_valid <= 1'b0;
    end
    else
    begin
      out_pixel <= pix_valid ? pix_d : out_pixel;
      out_valid <= pix_valid;
    end
  end

  // ==========================================================
  // Assertions
  property p_lock;
    @(posedge ref_clk) disable iff (rst)
    (reg_wr && !unlocked && reg_idx == IDX_MODE) |=> $stable(mode_q);
  endproperty
  a_lock: assert property (p_lock) else $error("locked write changed mode");

  property p_ptr_clear;
    @(posedge ref_clk) disable iff (rst)
    (reg_rd && reg_idx == IDX_MODE) |=> (fptr_q == 2'h0 && bptr_q == 2'h0);
  endproperty
  a_ptr_clear: assert property (p_ptr_clear) else $error("stack pointers not cleared");

  property p_ptr_adv;
    @(posedge ref_clk) disable iff (rst)
    (reg_wr && unlocked && reg_idx == IDX_FG && !reg_rd) |=>
      (fptr_q == ptr_next($past(fptr_q)));
  endproperty
  a_ptr_adv: assert property (p_ptr_adv) else $error("fg pointer did not advance");

  property p_enh;
    @(posedge ref_clk) disable iff (rst)
    !enhanced_mode |=> !en_q;
  endproperty
  a_enh: assert property (p_enh) else $error("cursor on outside enhanced mode");

  property p_frame_pos;
    @(posedge ref_clk) disable iff (rst)
    !frame_start |=> (fpos_q == $past(fpos_q));
  endproperty
  a_frame_pos: assert property (p_frame_pos) else $error("position moved mid frame");

  property p_fetch_len;
    @(posedge ref_clk) disable iff (rst)
    (line_start && row_hit) |=> mem_req [*1] ##[0:300] (mem_ack && wcnt_q == 3'h7 || line_start);
  endproperty
  a_fetch_len: assert property (p_fetch_len) else $error("fetch never finished");

  property p_win_inv;
    @(posedge ref_clk) disable iff (rst)
    (pix_valid && en_q && shit_q && col_hit && !x11_q && and_b && xor_b) |=>
      (out_pixel == ~$past(screen_pixel));
  endproperty
  a_win_inv: assert property (p_win_inv) else $error("windowing invert wrong");

  property p_x11_pass;
    @(posedge ref_clk) disable iff (rst)
    (pix_valid && x11_q && !and_b) |=> (out_pixel == $past(screen_pixel));
  endproperty
  a_x11_pass: assert property (p_x11_pass) else $error("X11 pass-through wrong");

  property p_off;
    @(posedge ref_clk) disable iff (rst)
    (pix_valid && !en_q) |=> (out_pixel == $past(screen_pixel));
  endproperty
  a_off: assert property (p_off) else $error("disabled cursor altered pixel");

endmodule // hco_overlay

//--- logic/hco_pkg.sv
/*
  Constants and types for the hardware cursor overlay.
  Assumes a byte-wide indexed control register port and 16-bit display memory words.
*/
package hco_pkg;
  // Register indices
  localparam logic [7:0] IDX_LOCK   = 8'h39;
  localparam logic [7:0] IDX_MODE   = 8'h45;
  localparam logic [7:0] IDX_XH     = 8'h46;
  localparam logic [7:0] IDX_XL     = 8'h47;
  localparam logic [7:0] IDX_YH     = 8'h48;
  localparam logic [7:0] IDX_YL     = 8'h49;
  localparam logic [7:0] IDX_FG     = 8'h4A;
  localparam logic [7:0] IDX_BG     = 8'h4B;
  localparam logic [7:0] IDX_STH    = 8'h4C;
  localparam logic [7:0] IDX_STL    = 8'h4D;
  localparam logic [7:0] IDX_COL_SKIP = 8'h4E;
  localparam logic [7:0] IDX_ROW_SKIP = 8'h4F;
  localparam logic [7:0] IDX_CONV   = 8'h55;
  localparam logic [7:0] UNLOCK_KEY = 8'hA0;
  // Field positions
  localparam int CONV_BIT   = 4;
  localparam int ENABLE_BIT = 0;
  // Geometry
  localparam int CUR_SIZE       = 64;
  localparam int WORDS_PER_ROW  = 4;
  localparam int SEG_WORD_SHIFT = 9;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef struct packed {
    logic [10:0] x;
    logic [10:0] y;
    logic [5:0]  col_skip;
    logic [5:0]  row_skip;
  } hco_pos_s;

  typedef enum logic [0:0] {
    HCO_IDLE  = 1'b0,
    HCO_FETCH = 1'b1
  } hco_state_e;
endpackage

//--- dv/hco_mem_model.sv
/*
  Display memory model for the cursor overlay's mask fetch port.
  Assumes mem_addr is held stable until the acknowledge is seen, as the overlay does.
*/
`timescale 1ns/100ps
module hco_mem_model #(
  parameter int AW = 20
)(
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          mem_req,
  input  wire logic [AW-1:0] mem_addr,
  input  wire logic [2:0]    delay,
  output logic               mem_ack,
  output logic      [15:0]   mem_rdata
);
  // ==========================================
  // Answer engine
  logic [AW-1:0] seen[$];
  logic [2:0]    wait_q;
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      mem_ack   <= 1'b0;
      wait_q    <= 3'h0;
      mem_rdata <= 16'hA5A5;
    end
    else if (mem_ack)
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_q    <= delay;
    end
    else if (mem_req && wait_q == 3'h0)
    begin
      mem_ack   <= 1'b1;
      // Even words hold AND bits, odd words XOR bits
      // Shape is 64x63: the last row is padded AND 1, XOR 0
      if (mem_addr[8:3] == 6'h3F)
        mem_rdata <= mem_addr[0] ? 16'h0000 : 16'hFFFF;
      else
        mem_rdata <= mem_addr[0] ? 16'hF0F0 : 16'hFF00;
      seen.push_back(mem_addr);
    end
    else
    begin
      // Stale data never looks valid between answers
      mem_rdata <= ~mem_rdata;
      if (wait_q != 3'h0)
        wait_q <= wait_q - 3'h1;
    end
  end
endmodule // hco_mem_model

//--- dv/hardware_cursor_overlay_tb.sv
/*
  Self-checking bench for the cursor overlay: register programming, fetch and pixel mix.
  Assumes hco_overlay and hco_mem_model are compiled first; random values come from an LFSR.
*/
`timescale 1ns/100ps
module hardware_cursor_overlay_tb;
  import hco_pkg::*;
  logic        ref_clk, rst, reg_wr, reg_rd, enhanced_mode, frame_start, line_start;
  logic        pix_valid, out_valid, mem_req, mem_ack, cursor_on, conv, en;
  logic [7:0]  reg_idx, reg_wdata, reg_rdata;
  logic [10:0] active_height, fetch_line, hpos, vpos, px, py, seg;
  logic [23:0] screen_pixel, out_pixel, fg, bg, scr;
  logic [19:0] mem_addr;
  logic [15:0] mem_rdata;
  logic [5:0]  pox, poy;
  logic [2:0]  delay;
  logic [31:0] seed;
  int          fails, comparisons, t, i, h, ln;

  hco_overlay #(.MEM_AW(20)) hco_overlay_i (.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .enhanced_mode(enhanced_mode), .active_height(active_height), .frame_start(frame_start),
    .line_start(line_start), .fetch_line(fetch_line), .pix_valid(pix_valid), .hpos(hpos),
    .vpos(vpos), .screen_pixel(screen_pixel), .out_pixel(out_pixel), .out_valid(out_valid),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .cursor_on(cursor_on));
  hco_mem_model #(.AW(20)) hco_mem_model_i (.ref_clk(ref_clk), .rst(rst), .mem_req(mem_req),
    .mem_addr(mem_addr), .delay(delay), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // ==========================================
  // Helpers
  function automatic logic [23:0] exp_pix(int hh, int l);
    int  c, r;
    logic a, x;
    c = hh - int'(px) + int'(pox);
    r = l - int'(py) + int'(poy);
    if (!en || hh < int'(px) || l < int'(py) || c > 63 || r > 63 || py >= active_height)
      return scr;
    // Last row is padding in the memory model: transparent in windowing mode, bg in X11 mode
    a = (r == 63) || ((c % 16) < 8);
    x = (r != 63) && ((c % 8) < 4);
    if (conv)
      return a ? (x ? fg : bg) : scr;
    return a ? (x ? ~scr : scr) : (x ? fg : bg);
  endfunction
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic nxt();
    seed = lfsr_next(seed);
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic w(logic [7:0] ix, logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_idx <= ix;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] ix);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_idx <= ix;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
  endtask
  task automatic line(int l);
    int r, k;
    r = l - int'(py) + int'(poy);
    hco_mem_model_i.seen.delete();
    @(posedge ref_clk);
    line_start <= 1'b1;
    fetch_line <= 11'(l);
    vpos <= 11'(l);
    @(posedge ref_clk);
    line_start <= 1'b0;
    for (k = 0; k < 200; k++)
    begin
      @(posedge ref_clk);
      #1;
      if (!mem_req)
        break;
    end
    if (en && l >= int'(py) && r < 64 && py < active_height)
    begin
      chk("fetch count", hco_mem_model_i.seen.size(), 8);
      if (hco_mem_model_i.seen.size() == 8)
        for (k = 0; k < 8; k++)
          chk("fetch addr", hco_mem_model_i.seen[k], (int'(seg) << 9) + r * 8 + k);
    end
  endtask
  task automatic pix(int hh, int l);
    nxt();
    scr = seed[23:0];
    @(posedge ref_clk);
    pix_valid <= 1'b1;
    hpos <= 11'(hh);
    screen_pixel <= scr;
    @(posedge ref_clk);
    pix_valid <= 1'b0;
    #1;
    chk("pixel", out_pixel, exp_pix(hh, l));
    chk("out_valid", out_valid, 1'b1);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================
  // Clock, watchdog, main sequence
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end
  initial
  begin
    {reg_wr, reg_rd, frame_start, line_start, pix_valid} = '0;
    {reg_idx, reg_wdata, fetch_line, hpos, vpos, screen_pixel} = '0;
    enhanced_mode = 1'b1;
    active_height = 11'd120;
    delay = 3'h0;
    rst = 1'b1;
    fails = 0;
    comparisons = 0;
    seed = 32'h2BE742F3;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    for (t = 0; t < 12; t++)
    begin
      nxt();
      px = (t == 0) ? 11'h000 : {1'b0, seed[9:0]};
      pox = (t == 0) ? 6'h3F : seed[15:10];
      delay <= seed[18:16];
      nxt();
      py = (t == 0) ? 11'h000 : {4'h0, seed[6:0]};
      poy = (t == 0) ? 6'h3F : seed[12:7];
      conv = seed[13];
      seg = seed[26:16];
      nxt();
      fg = seed[23:0];
      nxt();
      bg = seed[23:0];
      en = (t != 1);
      enhanced_mode <= (t != 1);
      w(IDX_LOCK, UNLOCK_KEY);
      w(IDX_MODE, 8'h01);
      w(IDX_CONV, {3'h0, conv, 4'h0});
      rd(IDX_MODE);
      chk("mode", reg_rdata, 8'h01);
      for (i = 0; i < 3; i++)
        w(IDX_FG, fg[8*i+:8]);
      w(IDX_FG, 8'hEE);
      fg[7:0] = 8'hEE;
      for (i = 0; i < 3; i++)
        w(IDX_BG, bg[8*i+:8]);
      rd(IDX_BG);
      chk("bg byte", reg_rdata, bg[7:0]);
      rd(IDX_MODE);
      rd(IDX_FG);
      chk("fg byte", reg_rdata, 8'hEE);
      w(IDX_XH, {5'h0, px[10:8]});
      w(IDX_XL, px[7:0]);
      w(IDX_YH, {5'h0, py[10:8]});
      w(IDX_YL, py[7:0]);
      w(IDX_COL_SKIP, {2'h0, pox});
      w(IDX_ROW_SKIP, {2'h0, poy});
      w(IDX_STH, {5'h0, seg[10:8]});
      w(IDX_STL, seg[7:0]);
      w(IDX_LOCK, 8'h00);
      if (t == 2)
        w(IDX_MODE, 8'h00);
      @(posedge ref_clk);
      frame_start <= 1'b1;
      @(posedge ref_clk);
      frame_start <= 1'b0;
      // Mid-frame move must not show until the next frame
      w(IDX_LOCK, UNLOCK_KEY);
      w(IDX_XL, px[7:0] + 8'h05);
      w(IDX_LOCK, 8'h00);
      ln = int'(py) + ((t == 0) ? 0 : int'(seed[29:24]));
      if (py < active_height && ln >= int'(active_height))
        ln = int'(active_height) - 1;
      line(ln);
      line(ln + 1);
      chk("cursor_on", cursor_on, en);
      for (h = int'(px) - 2; h < int'(px) + 66; h++)
        if (h >= 0)
          pix(h, ln);
      $display("test %0d done", t);
    end
    end_of_test();
  end
endmodule // hardware_cursor_overlay_tb
